// ==== hw/spv_pkg.sv ====
// Constants, register map and types of the servo position/velocity regulator.
// Notes on behaviour
// (RL1) Always-active mode integrates and applies the integral term every update.
// (RL2) Current-gated mode: threshold is percent of rated current; freeze above.
// (RL3) Velocity-gated mode: integrate below threshold, hold while command exceeds it.
// (RL4) Velocity-gated hold also needs feedback and command above 2 rad/s.
// (RL5) Position-error-gated mode: integrate below threshold, hold above it.
// (RL6) Derivative term is gain times error change; gain spans 0 to 10000.
// (RL7) Velocity command low-pass, 0 to 10000 Hz; zero bypasses it.
// (RL8) Position loop output is proportional gain times error; gain 0 to 700.
// (RL9) Feedforward from position command change, scaled 0 to 100 percent.
// (RL10) Feedforward low-pass, 0 to 800 Hz; zero disables it.
// (RL11) Signed offset 0 to 450 added while error exceeds high threshold.
// (RL12) High-error threshold spans 0 to 50000 counts.
// (RL13) Reset values: position gain 20, feedforward gain 0.
// (RL14) Loops compute once per 200 us; delays use previous update values.
// (RL15) Integral gain is inverse integrator time; time zero disables integrator.
// (RL16) While drive is disabled the integral is loaded with the bias.
// (RL17) Threshold tests use magnitudes; offset follows position error sign.
// (RL18) Setting changes take effect only at the next update start.
package spv_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int UPDATE_US = 200;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * UPDATE_US;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int NUM_REGS = 16;

  // Register indices; the address port carries the index.
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_POS_GAIN = 4'h1;
  localparam logic [3:0] REG_FF_GAIN = 4'h2;
  localparam logic [3:0] REG_FF_BW = 4'h3;
  localparam logic [3:0] REG_HE_OFFSET = 4'h4;
  localparam logic [3:0] REG_HE_THRESH = 4'h5;
  localparam logic [3:0] REG_VEL_P = 4'h6;
  localparam logic [3:0] REG_INT_TIME = 4'h7;
  localparam logic [3:0] REG_VEL_D = 4'h8;
  localparam logic [3:0] REG_VEL_BW = 4'h9;
  localparam logic [3:0] REG_INT_THRESH = 4'hA;
  localparam logic [3:0] REG_I_RATED = 4'hB;
  localparam logic [3:0] REG_I_BIAS = 4'hC;
  localparam logic [3:0] REG_STATUS = 4'hD;
  localparam logic [3:0] REG_CUR_OUT = 4'hE;
  localparam logic [3:0] REG_VEL_OUT = 4'hF;
  localparam logic [3:0] LAST_RW_REG = REG_I_BIAS;

  // Setting ranges.
  localparam logic [31:0] MODE_MAX = 32'h0000_0003;
  localparam logic [31:0] POS_GAIN_MAX = 32'd700;
  localparam logic [31:0] FF_GAIN_MAX = 32'd100;
  localparam logic [31:0] FF_BW_MAX = 32'd800;
  localparam logic [31:0] HE_OFFSET_MAX = 32'd450;
  localparam logic [31:0] HE_THRESH_MAX = 32'd50000;
  localparam logic [31:0] VEL_P_MAX = 32'd500;
  localparam logic [31:0] INT_TIME_MAX = 32'd60000;
  localparam logic [31:0] VEL_D_MAX = 32'd10000;
  localparam logic [31:0] VEL_BW_MAX = 32'd10000;
  localparam logic [31:0] NO_LIMIT = 32'hFFFF_FFFF;

  // Reset values.
  localparam logic [31:0] POS_GAIN_RESET = 32'd20;
  localparam logic [31:0] FF_GAIN_RESET = 32'd0;
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;

  // Fixed-point scaling.
  localparam int GAIN_SHIFT = 8;
  localparam int INT_SHIFT = 8;
  localparam logic signed [63:0] PCT_DIV = 64'sd100;
  localparam logic [31:0] MIN_VEL_RAD_S = 32'd2;
  localparam logic [31:0] ALPHA_PER_HZ = 32'd82;
  localparam logic [31:0] ALPHA_ONE = 32'h0001_0000;
  localparam int ALPHA_SHIFT = 16;

  // Status bit positions.
  localparam int ST_FROZEN = 0;
  localparam int ST_OFFSET = 1;
  localparam int ST_ENABLE = 2;

  typedef enum logic [1:0] {
    SPV_INT_ALWAYS = 2'h0,
    SPV_INT_CURRENT = 2'h1,
    SPV_INT_VEL_CMD = 2'h2,
    SPV_INT_POS_ERR = 2'h3
  } spv_int_mode_type;

endpackage : spv_pkg

// ==== hw/spv_filt_if.sv ====
// Link between the regulator core and one first-order low-pass filter.
`timescale 1ns/1ps
interface spv_filt_if;
  logic step;
  logic [31:0] bw;
  logic signed [31:0] x;
  logic signed [31:0] y;
  modport user (output step, output bw, output x, input y);
  modport filt (input step, input bw, input x, output y);
endinterface : spv_filt_if

// ==== hw/spv_lpf.sv ====
// First-order low-pass filter updated once per regulator step.
`timescale 1ns/1ps
module spv_lpf
  import spv_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Filter link.
  spv_filt_if.filt f
);

  logic signed [31:0] state;
  logic [31:0] alpha;
  logic signed [63:0] diff;
  logic signed [63:0] prod;

  // Alpha approximates 2*pi*bw*Ts in 16-bit fraction, saturating at one.
  always_comb begin
    alpha = f.bw * ALPHA_PER_HZ;
    if (f.bw > (ALPHA_ONE / ALPHA_PER_HZ)) begin
      alpha = ALPHA_ONE;
    end
    diff = 64'(f.x) - 64'(state);
    prod = (diff * $signed({32'h0000_0000, alpha})) >>> ALPHA_SHIFT;
    if (f.bw == 32'h0000_0000) begin
      f.y = f.x; // see (RL7) see (RL10)
    end else begin
      f.y = 32'(64'(state) + prod);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (f.step) begin
      state <= f.y; // see (RL14)
    end
  end

  a_bypass_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    f.step && f.bw == 32'h0000_0000 |=> state == $past(f.x)) // see (RL7)
    else $error("filter with zero bandwidth did not pass its input");

endmodule : spv_lpf

// ==== hw/spv_regulator.sv ====
// Position loop feeding a velocity loop that produces the current command.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module spv_regulator
  import spv_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES,
  parameter logic [31:0] VEL_PER_RAD_S = 32'h0000_0001
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Command and feedback, same clock.
  input wire logic signed [31:0] pos_command,
  input wire logic signed [31:0] pos_feedback,
  input wire logic signed [31:0] vel_feedback,
  // Drive enable pin.
  input wire logic drive_enable,
  // Outputs to the current regulator.
  output logic signed [31:0] current_cmd,
  output logic signed [31:0] velocity_cmd,
  output logic update_done
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] reg_limit(input logic [3:0] idx);
    unique case (idx)
      REG_MODE: reg_limit = MODE_MAX;
      REG_POS_GAIN: reg_limit = POS_GAIN_MAX;
      REG_FF_GAIN: reg_limit = FF_GAIN_MAX;
      REG_FF_BW: reg_limit = FF_BW_MAX;
      REG_HE_OFFSET: reg_limit = HE_OFFSET_MAX;
      REG_HE_THRESH: reg_limit = HE_THRESH_MAX;
      REG_VEL_P: reg_limit = VEL_P_MAX;
      REG_INT_TIME: reg_limit = INT_TIME_MAX;
      REG_VEL_D: reg_limit = VEL_D_MAX;
      REG_VEL_BW: reg_limit = VEL_BW_MAX;
      default: reg_limit = NO_LIMIT;
    endcase
  endfunction : reg_limit

  function automatic logic [31:0] reg_reset(input logic [3:0] idx);
    if (idx == REG_POS_GAIN) begin
      reg_reset = POS_GAIN_RESET; // see (RL13)
    end else if (idx == REG_FF_GAIN) begin
      reg_reset = FF_GAIN_RESET; // see (RL13)
    end else begin
      reg_reset = ZERO_RESET;
    end
  endfunction : reg_reset

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    mag = v[31] ? 32'(-v) : 32'(v);
  endfunction : mag

  function automatic logic signed [31:0] scale(input logic signed [31:0] v,
                                               input logic [31:0] g);
    logic signed [63:0] p;
    p = (64'(v) * $signed({32'h0000_0000, g})) >>> GAIN_SHIFT;
    scale = 32'(p);
  endfunction : scale

  ////////////////////////////////////////////////////////////////////////////
  // Register file and settings snapshot.

  logic [31:0] cfg [NUM_REGS];
  logic [31:0] shadow [NUM_REGS];
  logic [31:0] status;
  logic tick;
  logic calc_en;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg[i] <= reg_reset(4'(i));
      end
    end else if (reg_wr && reg_addr <= LAST_RW_REG) begin
      if (reg_wdata > reg_limit(reg_addr)) begin
        cfg[reg_addr] <= reg_limit(reg_addr); // see (RL6) see (RL8) see (RL12)
      end else begin
        cfg[reg_addr] <= reg_wdata;
      end
    end
  end

  // Settings are sampled only on the tick so one update never mixes them.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        shadow[i] <= reg_reset(4'(i));
      end
    end else if (tick) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        shadow[i] <= cfg[i]; // see (RL18)
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: reg_rdata <= status;
        REG_CUR_OUT: reg_rdata <= current_cmd;
        REG_VEL_OUT: reg_rdata <= velocity_cmd;
        default: reg_rdata <= cfg[reg_addr];
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update tick and input capture.

  logic [31:0] tick_cnt;
  logic en_meta;
  logic en_sync;
  logic s_en;
  logic signed [31:0] s_pos_cmd;
  logic signed [31:0] s_pos_fb;
  logic signed [31:0] s_vel_fb;

  assign tick = (tick_cnt == 32'(TICK_PERIOD - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      calc_en <= 1'b0;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001; // see (RL14)
      calc_en <= tick;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      en_meta <= drive_enable;
      en_sync <= en_meta;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_en <= 1'b0;
      s_pos_cmd <= '0;
      s_pos_fb <= '0;
      s_vel_fb <= '0;
    end else if (tick) begin
      s_en <= en_sync;
      s_pos_cmd <= pos_command;
      s_pos_fb <= pos_feedback;
      s_vel_fb <= vel_feedback;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position loop.

  spv_filt_if ff_if ();
  spv_filt_if vf_if ();

  logic signed [31:0] prev_pos_cmd;
  logic signed [31:0] pos_err;
  logic signed [31:0] ff_raw;
  logic signed [31:0] offset;
  logic offset_on;
  logic signed [31:0] next_vel_cmd;

  always_comb begin
    pos_err = s_pos_cmd - s_pos_fb;
    ff_raw = 32'((64'(s_pos_cmd - prev_pos_cmd) *
                  $signed({32'h0000_0000, shadow[REG_FF_GAIN]})) /
                 PCT_DIV); // see (RL9)
    offset_on = mag(pos_err) > shadow[REG_HE_THRESH]; // see (RL11) see (RL17)
    offset = '0;
    if (offset_on) begin
      offset = pos_err[31] ? 32'(-shadow[REG_HE_OFFSET])
                           : 32'(shadow[REG_HE_OFFSET]); // see (RL17)
    end
    next_vel_cmd = scale(pos_err, shadow[REG_POS_GAIN]) + ff_if.y + offset;
  end // see (RL8) see (RL11)

  assign ff_if.step = calc_en;
  assign ff_if.bw = shadow[REG_FF_BW];
  assign ff_if.x = ff_raw; // see (RL10)

  spv_lpf u_ff_lpf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .f(ff_if.filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Velocity loop.

  assign vf_if.step = calc_en;
  assign vf_if.bw = shadow[REG_VEL_BW];
  assign vf_if.x = next_vel_cmd; // see (RL7)

  spv_lpf u_vel_lpf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .f(vf_if.filt)
  );

  logic signed [31:0] prev_vel_err;
  logic signed [31:0] integ;
  logic signed [31:0] vel_err;
  logic signed [31:0] d_term;
  logic signed [31:0] i_step;
  logic [31:0] cur_thresh;
  logic [31:0] min_vel;
  logic int_gate;
  spv_int_mode_type mode;

  always_comb begin
    mode = spv_int_mode_type'(shadow[REG_MODE][1:0]);
    vel_err = vf_if.y - s_vel_fb;
    d_term = scale(vel_err - prev_vel_err, shadow[REG_VEL_D]); // see (RL6)
    cur_thresh = 32'((64'(shadow[REG_INT_THRESH]) *
                      64'(shadow[REG_I_RATED])) / PCT_DIV); // see (RL2)
    min_vel = MIN_VEL_RAD_S * VEL_PER_RAD_S;
    i_step = '0;
    if (shadow[REG_INT_TIME] != 32'h0000_0000) begin
      i_step = 32'((64'(vel_err) <<< INT_SHIFT) /
                   $signed({32'h0000_0000, shadow[REG_INT_TIME]})); // see (RL15)
    end
    unique case (mode)
      SPV_INT_ALWAYS: int_gate = 1'b1; // see (RL1)
      SPV_INT_CURRENT: int_gate = mag(current_cmd) < cur_thresh; // see (RL2)
      SPV_INT_VEL_CMD: int_gate = !(mag(vf_if.y) > shadow[REG_INT_THRESH] &&
                                    mag(vf_if.y) > min_vel &&
                                    mag(s_vel_fb) > min_vel); // see (RL3) see (RL4)
      SPV_INT_POS_ERR: int_gate = mag(pos_err) < shadow[REG_INT_THRESH]; // see (RL5)
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      integ <= '0;
    end else if (calc_en) begin
      if (!s_en) begin
        integ <= shadow[REG_I_BIAS]; // see (RL16)
      end else if (int_gate) begin
        integ <= integ + i_step; // see (RL1) see (RL15)
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_pos_cmd <= '0;
      prev_vel_err <= '0;
      velocity_cmd <= '0;
      current_cmd <= '0;
      status <= '0;
    end else if (calc_en) begin
      prev_pos_cmd <= s_pos_cmd; // see (RL14)
      prev_vel_err <= vel_err;
      velocity_cmd <= vf_if.y;
      current_cmd <= scale(vel_err, shadow[REG_VEL_P]) + integ + d_term;
      status <= '0;
      status[ST_FROZEN] <= s_en && !int_gate;
      status[ST_OFFSET] <= offset_on;
      status[ST_ENABLE] <= s_en;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      update_done <= 1'b0;
    end else begin
      update_done <= calc_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic kp_written;
  logic saw_disabled;

  // Remembers a disabled update so the cover can see the later enable.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      saw_disabled <= 1'b0;
    end else if (calc_en && !s_en) begin
      saw_disabled <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kp_written <= 1'b0;
    end else if (reg_wr && reg_addr == REG_POS_GAIN) begin
      kp_written <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_tick_spacing: assert property (tick |=> !tick [*8]) // see (RL14)
    else $error("update ticks came too close together");
  a_kp_default: assert property (!kp_written |->
    shadow[REG_POS_GAIN] == POS_GAIN_RESET
    && cfg[REG_FF_GAIN] <= FF_GAIN_MAX) // see (RL13)
    else $error("position gain left its reset value unwritten");
  a_bias_load: assert property (calc_en && !s_en |=>
    integ == $past(shadow[REG_I_BIAS])) // see (RL16)
    else $error("integral not loaded with bias while disabled");
  a_int_hold: assert property (calc_en && s_en && !int_gate |=>
    $stable(integ)) // see (RL3)
    else $error("gated integrator moved");
  a_always_on: assert property (calc_en && s_en && mode == SPV_INT_ALWAYS |=>
    integ == $past(integ) + $past(i_step)) // see (RL1)
    else $error("always-on integrator did not accumulate");
  a_ti_zero: assert property (calc_en && s_en &&
    shadow[REG_INT_TIME] == 32'h0000_0000 |=> $stable(integ)) // see (RL15)
    else $error("integrator ran with zero integrator time");
  a_vel_min: assert property (calc_en && mode == SPV_INT_VEL_CMD &&
    mag(s_vel_fb) <= min_vel |-> int_gate) // see (RL4)
    else $error("velocity gate froze below minimum speed");
  a_cur_gate: assert property (calc_en && mode == SPV_INT_CURRENT &&
    mag(current_cmd) > cur_thresh |-> !int_gate) // see (RL2)
    else $error("current gate did not freeze above threshold");
  a_perr_gate: assert property (calc_en && mode == SPV_INT_POS_ERR &&
    mag(pos_err) > shadow[REG_INT_THRESH] |-> !int_gate) // see (RL5)
    else $error("position error gate did not freeze");
  a_offset_flag: assert property (calc_en && offset_on |=>
    status[ST_OFFSET] ##1 !calc_en) // see (RL11)
    else $error("offset status not reported");
  a_snap_hold: assert property (!tick |=>
    shadow[REG_POS_GAIN] == $past(shadow[REG_POS_GAIN])) // see (RL18)
    else $error("settings changed in mid update");
  a_range_keep: assert property (cfg[REG_HE_THRESH] <= HE_THRESH_MAX &&
    cfg[REG_VEL_D] <= VEL_D_MAX && cfg[REG_POS_GAIN] <= POS_GAIN_MAX)
    else $error("setting outside its range"); // see (RL12)

  c_frozen: cover property (calc_en && s_en && !int_gate);
  c_offset: cover property (calc_en && offset_on && pos_err[31]);
  c_enable: cover property (calc_en && s_en && saw_disabled);

endmodule : spv_regulator

// ==== dv/spv_motor_model.sv ====
// Motor and position feedback model at the far side of the regulator.
`timescale 1ns/1ps
module spv_motor_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Regulator outputs.
  input wire logic signed [31:0] current_cmd,
  input wire logic update_done,
  // Hold pins the feedback to the given values.
  input wire logic hold,
  input wire logic signed [31:0] hold_pos,
  input wire logic signed [31:0] hold_vel,
  // Feedback to the regulator.
  output logic signed [31:0] pos_feedback,
  output logic signed [31:0] vel_feedback
);
  // Speed integrates current and position integrates speed, per update.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos_feedback <= 32'sh0000_0000;
      vel_feedback <= 32'sh0000_0000;
    end else if (hold) begin
      pos_feedback <= hold_pos;
      vel_feedback <= hold_vel;
    end else if (update_done) begin
      vel_feedback <= vel_feedback + (current_cmd >>> 6);
      pos_feedback <= pos_feedback + (vel_feedback >>> 6);
    end
  end
endmodule : spv_motor_model

// ==== dv/servo_position_velocity_regulator_tb_top.sv ====
// Self-checking bench for the servo position and velocity regulator.
`timescale 1ns/1ps
module servo_position_velocity_regulator_tb_top;
  import spv_pkg::*;
  localparam int TP = 40;
  logic clk_sys;
  logic rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic signed [31:0] pos_command;
  logic signed [31:0] pos_feedback;
  logic signed [31:0] vel_feedback;
  logic drive_enable;
  logic signed [31:0] current_cmd;
  logic signed [31:0] velocity_cmd;
  logic update_done;
  logic hold;
  logic signed [31:0] hold_vel;
  int failures;
  int check_count;

  spv_regulator #(.TICK_PERIOD(TP), .VEL_PER_RAD_S(32'h0000_0001))
    spv_regulator_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_command(pos_command),
    .pos_feedback(pos_feedback), .vel_feedback(vel_feedback),
    .drive_enable(drive_enable), .current_cmd(current_cmd),
    .velocity_cmd(velocity_cmd), .update_done(update_done));
  spv_motor_model spv_motor_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .current_cmd(current_cmd), .update_done(update_done), .hold(hold),
    .hold_pos(32'sh0000_0000), .hold_vel(hold_vel),
    .pos_feedback(pos_feedback), .vel_feedback(vel_feedback));

  always #12.5 clk_sys = ~clk_sys;

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, $signed(exp),
               $signed(got));
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rchk(input string what, input logic [3:0] a,
                      input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask : rchk

  task automatic wait_upd(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        #1 k++;
      end while (update_done !== 1'b1 && k < 2 * TP);
      if (k >= 2 * TP) chk("update_done", 32'h1, 32'(update_done));
    end
  endtask : wait_upd

  task automatic setin(input logic signed [31:0] p,
                       input logic signed [31:0] v);
    @(posedge clk_sys);
    pos_command <= p;
    hold_vel <= v;
  endtask : setin

  // Compares the integral step between two settled updates.
  task automatic step_chk(input string what, input logic [31:0] exp);
    logic signed [31:0] c0;
    wait_upd(3);
    c0 = current_cmd;
    wait_upd(1);
    chk(what, exp, current_cmd - c0);
  endtask : step_chk

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("pos gain reset", REG_POS_GAIN, 32'h0000_0014);
    rchk("ff gain reset", REG_FF_GAIN, 32'h0000_0000);
    chk("current after reset", 32'h0000_0000, current_cmd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_period;
    time t0;
    wait_upd(1);
    t0 = $time;
    wait_upd(1);
    chk("update period", TP, 32'(($time - t0) / 25));
    $display("test period done");
  endtask : t_period

  task automatic t_clamp;
    logic [3:0] a[7] = '{REG_POS_GAIN, REG_FF_GAIN, REG_FF_BW, REG_HE_OFFSET,
                         REG_HE_THRESH, REG_VEL_D, REG_VEL_BW};
    logic [31:0] e[7] = '{POS_GAIN_MAX, FF_GAIN_MAX, FF_BW_MAX,
                          HE_OFFSET_MAX, HE_THRESH_MAX, VEL_D_MAX, VEL_BW_MAX};
    for (int i = 0; i < 7; i++) begin
      wr(a[i], e[i] + 32'h0000_0001);
      rchk("clamped setting", a[i], e[i]);
    end
    wr(REG_CUR_OUT, 32'h0000_1234);
    rchk("read-only current", REG_CUR_OUT, 32'h0000_0000);
    wr(REG_FF_GAIN, 32'h0000_0000);
    wr(REG_HE_OFFSET, 32'h0000_0000);
    wr(REG_VEL_BW, 32'h0000_0000);
    $display("test clamp done");
  endtask : t_clamp

  task automatic t_pos;
    wr(REG_POS_GAIN, 32'h0000_0014);
    setin(32'sh0000_0500, 32'sh0000_0000);
    wait_upd(3);
    chk("vel from gain", 32'h0000_0064, velocity_cmd);
    wr(REG_POS_GAIN, 32'h0000_0028);
    chk("vel before tick", 32'h0000_0064, velocity_cmd);
    wait_upd(3);
    chk("vel new gain", 32'h0000_00C8, velocity_cmd);
    $display("test position gain done");
  endtask : t_pos

  task automatic t_offset;
    logic [31:0] d;
    wr(REG_POS_GAIN, 32'h0000_0014);
    wr(REG_HE_OFFSET, 32'h0000_0032);
    wr(REG_HE_THRESH, 32'h0000_03E8);
    wait_upd(3);
    chk("offset added", 32'h0000_0096, velocity_cmd);
    rd(REG_STATUS, d);
    chk("offset flag", 32'h1, 32'(d[ST_OFFSET]));
    setin(-32'sh0000_0500, 32'sh0000_0000);
    wait_upd(3);
    chk("offset signed", -32'sh0000_0096, velocity_cmd);
    setin(32'sh0000_03E8, 32'sh0000_0000);
    wait_upd(3);
    chk("offset at edge", 32'h0000_004E, velocity_cmd);
    $display("test offset done");
  endtask : t_offset

  task automatic t_ff;
    wr(REG_POS_GAIN, 32'h0000_0000);
    wr(REG_HE_OFFSET, 32'h0000_0000);
    wr(REG_FF_GAIN, 32'h0000_0032);
    for (int b = 0; b < 2; b++) begin
      wr(REG_FF_BW, b * 32'h0000_0320);
      repeat (4) begin
        wait_upd(1);
        @(posedge clk_sys);
        pos_command <= pos_command + 32'sh0000_0064;
      end
      chk("feedforward", 32'h0000_0032, velocity_cmd);
    end
    wr(REG_FF_GAIN, 32'h0000_0000);
    $display("test feedforward done");
  endtask : t_ff

  task automatic t_integ;
    wr(REG_I_BIAS, 32'h0000_012C);
    setin(32'sh0000_0000, -32'sh0000_0028);
    wait_upd(4);
    chk("bias loaded", 32'h0000_012C, current_cmd);
    @(posedge clk_sys);
    drive_enable <= 1'b1;
    step_chk("zero time", 32'h0000_0000);
    wr(REG_INT_TIME, 32'h0000_0100);
    step_chk("always on", 32'h0000_0028);
    wr(REG_MODE, 32'(SPV_INT_POS_ERR));
    wr(REG_INT_THRESH, 32'h0000_0064);
    setin(32'sh0000_0500, -32'sh0000_0028);
    step_chk("pos err held", 32'h0000_0000);
    setin(32'sh0000_0032, -32'sh0000_0028);
    step_chk("pos err runs", 32'h0000_0028);
    wr(REG_MODE, 32'(SPV_INT_CURRENT));
    wr(REG_I_RATED, 32'h0000_0064);
    step_chk("current held", 32'h0000_0000);
    wr(REG_INT_THRESH, 32'h0000_2710);
    step_chk("current runs", 32'h0000_0028);
    wr(REG_MODE, 32'(SPV_INT_VEL_CMD));
    wr(REG_INT_THRESH, 32'h0000_0064);
    wr(REG_POS_GAIN, 32'h0000_0100);
    setin(32'sh0000_0500, -32'sh0000_0028);
    step_chk("vel cmd held", 32'h0000_0000);
    setin(32'sh0000_0500, 32'sh0000_0001);
    step_chk("slow feedback", 32'h0000_04FF);
    $display("test integrator done");
  endtask : t_integ

  task automatic t_follow;
    wr(REG_MODE, 32'(SPV_INT_ALWAYS));
    wr(REG_INT_TIME, 32'h0000_0000);
    wr(REG_POS_GAIN, 32'h0000_0014);
    wr(REG_VEL_P, 32'h0000_0100);
    setin(32'sh0000_1388, 32'sh0000_0000);
    @(posedge clk_sys);
    hold <= 1'b0;
    wait_upd(20);
    chk("motor moved", 32'h1, 32'(pos_feedback > 32'sh0000_0000));
    $display("test follow done");
  endtask : t_follow

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pos_command = '0;
    drive_enable = 1'b0;
    hold = 1'b1;
    hold_vel = '0;
    failures = 0;
    check_count = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_period;
    t_clamp;
    t_pos;
    t_offset;
    t_ff;
    t_integ;
    t_follow;
    results;
  end

  // The run needs about a hundred updates; this leaves ample margin.
  initial begin
    #(25 * TP * 400);
    failures++;
    results;
  end
endmodule : servo_position_velocity_regulator_tb_top
